// file: rtl/flash_host_pkg.sv
// constants and types for the parallel flash bus host
package flash_host_pkg;
  // bus widths
  localparam int ADDR_W = 20;
  localparam int DATA_W = 16;
  localparam int BYTE_W = 8;
  // address bits that select protect or unprotect, and the data pin that carries the byte address
  localparam int PROT_SEL_BIT = 6;
  localparam int PROT_HI_BIT = 1;
  localparam int PROT_LO_BIT = 0;
  localparam int TOP_DQ_BIT = 15;
  // clock period and device timing, in ns
  localparam int CLK_PERIOD_NS = 4;
  localparam int T_ACC_NS = 90;
  localparam int T_OE_NS = 25;
  localparam int T_WP_NS = 35;
  localparam int T_WPH_NS = 30;
  localparam int T_RP_NS = 500;
  localparam int T_RH_NS = 50;
  localparam int T_PROT_NS = 1000;
  // cycle counts: least times rounded up
  localparam int ACC_CYC = (T_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WP_CYC = (T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WPH_CYC = (T_WPH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RP_CYC = (T_RP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RH_CYC = (T_RH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PROT_CYC = (T_PROT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 9;
  // request opcodes
  localparam logic [1:0] OP_READ = 2'h0;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_PROTECT = 2'h2;
  localparam logic [1:0] OP_UNPROTECT = 2'h3;
  // sequencer states, gray along idle-setup-strobe-recover
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_SETUP = 3'h1,
    ST_STROBE = 3'h3,
    ST_RECOVER = 3'h2,
    ST_RESET = 3'h6,
    ST_RESUME = 3'h7
  } state_t;
endpackage

// file: rtl/flash_host.sv
// host sequencer that drives the parallel flash through its pins
`timescale 1ns/1ps
module flash_host
  import flash_host_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // user request
  input wire logic req_valid,
  output logic req_ready,
  input wire logic [1:0] req_op,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic req_low_byte,
  input wire logic [DATA_W-1:0] req_wdata,
  input wire logic byte_mode,
  input wire logic flash_reset_req,
  // user answer
  output logic rsp_valid,
  output logic [DATA_W-1:0] rsp_rdata,
  // flash pins
  output logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] dq_in,
  output logic [DATA_W-1:0] dq_out,
  output logic [DATA_W-1:0] dq_oe_n,
  output logic chip_sel_n,
  output logic out_en_n,
  output logic wr_en_n,
  output logic flash_rst_n,
  output logic high_voltage_level,
  output logic byte_word_sel
);
  state_t state;
  state_t next_state;
  logic [CNT_W-1:0] cnt;
  logic [1:0] op;
  logic was_standby;
  logic [DATA_W-1:0] dq_meta;
  logic [DATA_W-1:0] dq_sync;
  logic [DATA_W-1:0] next_rdata;
  logic [DATA_W-1:0] drive_mask;
  logic [CNT_W-1:0] strobe_len;
  wire is_read = (op == OP_READ);
  wire is_prot = (op == OP_PROTECT) || (op == OP_UNPROTECT);
  wire cnt_done = (cnt == '0);
  wire take = req_valid && req_ready;
  wire driving = (state == ST_SETUP || state == ST_STROBE) && !is_read;

  // two flops on the data pins since they come from outside the clock domain
  always_ff @(posedge sys_clk)
  begin
    dq_meta <= dq_in;
    dq_sync <= dq_meta;
  end

  // read strobe covers access time plus the two sync flops
  assign strobe_len = is_read ? CNT_W'(ACC_CYC + 2) : (is_prot ? CNT_W'(PROT_CYC) : CNT_W'(WP_CYC));
  assign req_ready = (state == ST_IDLE) && !flash_reset_req;

  // next state
  always_comb
  begin
    next_state = state;
    case (state)
      ST_IDLE:
        if (flash_reset_req) next_state = ST_RESET;
        else if (req_valid) next_state = ST_SETUP;
      ST_SETUP: next_state = ST_STROBE;
      ST_STROBE: if (cnt_done) next_state = ST_RECOVER;
      ST_RECOVER: if (cnt_done) next_state = ST_IDLE;
      ST_RESET: if (cnt_done && !flash_reset_req) next_state = ST_RESUME;
      ST_RESUME: if (cnt_done) next_state = ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
  end

  // state, counter and latched request
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      state <= ST_IDLE;
      cnt <= '0;
      op <= OP_READ;
      addr <= '0;
      dq_out <= '0;
      byte_word_sel <= 1'b1;
      was_standby <= 1'b1;
    end
    else
    begin
      state <= next_state;
      if (state != next_state)
        case (next_state)
          ST_STROBE: cnt <= strobe_len - CNT_W'(1);
          ST_RECOVER: cnt <= CNT_W'(WPH_CYC - 1);
          ST_RESET: cnt <= CNT_W'(RP_CYC - 1);
          ST_RESUME: cnt <= CNT_W'(RH_CYC - 1);
          default: cnt <= '0;
        endcase
      else if (!cnt_done)
        cnt <= cnt - CNT_W'(1);
      if (take)
      begin
        op <= req_op;
        addr <= req_addr;
        byte_word_sel <= !byte_mode;
        dq_out <= req_wdata;
        if (byte_mode)
          dq_out[TOP_DQ_BIT] <= req_low_byte;
        if (req_op == OP_PROTECT || req_op == OP_UNPROTECT)
        begin
          addr[PROT_SEL_BIT] <= (req_op == OP_UNPROTECT);
          addr[PROT_HI_BIT] <= 1'b1;
          addr[PROT_LO_BIT] <= 1'b0;
        end
      end
      if (state == ST_STROBE) was_standby <= 1'b0;
      else if (state == ST_RESET) was_standby <= 1'b1;
    end
  end

  // pin levels from state
  assign chip_sel_n = !(state == ST_SETUP || state == ST_STROBE);
  assign out_en_n = !(state == ST_STROBE && is_read);
  // one bus cycle per write request, so a bypass program is two requests
  assign wr_en_n = !(state == ST_STROBE && !is_read);
  assign flash_rst_n = !(state == ST_RESET);
  assign high_voltage_level = is_prot && (state == ST_SETUP || state == ST_STROBE);
  // byte mode keeps pin fifteen as address during any access; rest float on read
  assign drive_mask = byte_word_sel ? {DATA_W{driving}}
    : {1'b1, {(DATA_W-BYTE_W-1){1'b0}}, {BYTE_W{driving}}};
  assign dq_oe_n = ~drive_mask;

  // capture at strobe end; byte mode keeps only the low byte
  assign next_rdata = byte_word_sel ? dq_sync : {{(DATA_W-BYTE_W){1'b0}}, dq_sync[BYTE_W-1:0]};

  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      rsp_valid <= 1'b0;
      rsp_rdata <= '0;
    end
    else
    begin
      rsp_valid <= (state == ST_STROBE) && cnt_done && is_read;
      if ((state == ST_STROBE) && cnt_done && is_read)
        rsp_rdata <= next_rdata;
    end
  end

  // read strobe holds for at least 8 cycles with chip select low and write strobe high
  property read_strobe_len;
    @(posedge sys_clk) disable iff (!nrst)
      $fell(out_en_n) |-> (!out_en_n && chip_sel_n == 1'b0 && wr_en_n) [*8];
  endproperty
  read_low_a: assert property (read_strobe_len) else $error("read strobe too short");
  write_pins_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    !wr_en_n |-> !chip_sel_n && out_en_n) else $error("write levels wrong");
  no_contend_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    !out_en_n |-> (dq_oe_n[BYTE_W-1:0] == '1)) else $error("bus contention");
  byte_float_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    !byte_word_sel |-> dq_oe_n[TOP_DQ_BIT-1:BYTE_W] == '1 && !dq_oe_n[TOP_DQ_BIT])
    else $error("byte mode pins wrong");
  word_gate_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    byte_word_sel && chip_sel_n |-> dq_oe_n == '1) else $error("word pins driven idle");
  sequence reset_pulse;
    $fell(flash_rst_n) ##1 !flash_rst_n [*8];
  endsequence
  reset_hold_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    $fell(flash_rst_n) |-> reset_pulse) else $error("reset pulse short");
  reset_quiet_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    !flash_rst_n |-> chip_sel_n && wr_en_n && out_en_n) else $error("access during reset");
  prot_addr_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    high_voltage_level |-> addr[PROT_HI_BIT] && !addr[PROT_LO_BIT] && out_en_n
    && addr[PROT_SEL_BIT] == (op == OP_UNPROTECT)) else $error("protect levels wrong");
  rsp_time_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    rsp_valid |-> $past(!out_en_n, 1) && $past(!out_en_n, 8)) else $error("data taken early");
endmodule // flash_host

// file: sim/flash_dev_model.sv
// behavioural parallel flash device on the far side of the host
`timescale 1ns/1ps
module flash_dev_model
  import flash_host_pkg::*;
(
  // pins from the host
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] bus,
  input wire logic [DATA_W-1:0] host_oe_n,
  input wire logic chip_sel_n,
  input wire logic out_en_n,
  input wire logic wr_en_n,
  input wire logic flash_rst_n,
  input wire logic high_voltage_level,
  input wire logic byte_word_sel,
  // device side of the data pins
  output logic [DATA_W-1:0] dev_dq,
  output logic bad
);
  logic [7:0] mem [256];
  logic prot [256];
  logic [DATA_W-1:0] last = 16'h0000;
  logic acc_ok = 1'b0;
  realtime t_sel = 0;
  // address, read decode and outputs
  wire lsb = byte_word_sel ? 1'b0 : bus[TOP_DQ_BIT];
  wire [7:0] idx = {addr[6:0], lsb};
  wire rd = !chip_sel_n && !out_en_n && wr_en_n && flash_rst_n;
  wire [DATA_W-1:0] word = byte_word_sel ? {mem[idx | 8'h01], mem[idx]} : {8'h00, mem[idx]};
  // codes and status would share the low byte lanes
  wire [DATA_W-1:0] dev_en = !rd ? 16'h0000 : (byte_word_sel ? 16'hFFFF : 16'h00FF);
  // released lines show the inverse of the last value so stale data cannot pass
  assign dev_dq = (rd && acc_ok) ? word : (rd ? ~word : ~last);
  initial
  begin
    bad = 1'b0;
    for (int i = 0; i < 256; i++)
    begin
      mem[i] = 8'hFF;
      prot[i] = 1'b0;
    end
  end
  // a new select or address restarts the access time
  always @(negedge chip_sel_n or addr or lsb) t_sel = $realtime;
  always #1 acc_ok = ($realtime - t_sel) >= T_ACC_NS;
  always @(dev_dq) if (rd && acc_ok) last = dev_dq;
  // strobing read and write together, or driving against the device, is flagged
  always @(*) if ((!chip_sel_n && !out_en_n && !wr_en_n) || |(dev_en & ~host_oe_n)) bad = 1'b1;
  // commands latch on the falling write strobe; programming only clears bits
  // programming completes at once, so a later deselect cannot cut it
  always @(negedge wr_en_n)
    if (!chip_sel_n && out_en_n)
      if (high_voltage_level && addr[PROT_HI_BIT] && !addr[PROT_LO_BIT])
      begin
        if (addr[PROT_SEL_BIT]) foreach (prot[i]) prot[i] = 1'b0;
        else prot[addr[19:12]] = 1'b1;
      end
      else if (flash_rst_n && !high_voltage_level && !prot[addr[19:12]])
      begin
        mem[idx] &= bus[7:0];
        if (byte_word_sel) mem[idx | 8'h01] &= bus[15:8];
      end
endmodule // flash_dev_model

// file: sim/testbench.sv
// self-checking bench for the flash host sequencer
`timescale 1ns/1ps
module testbench;
  import flash_host_pkg::*;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic req_valid = 1'b0;
  logic [1:0] req_op = 2'h0;
  logic [ADDR_W-1:0] req_addr = 20'h00000;
  logic req_low_byte = 1'b0;
  logic [DATA_W-1:0] req_wdata = 16'h0000;
  logic byte_mode = 1'b0;
  logic flash_reset_req = 1'b0;
  wire req_ready, rsp_valid, chip_sel_n, out_en_n, wr_en_n, flash_rst_n;
  wire high_voltage_level, byte_word_sel, bad;
  wire [DATA_W-1:0] rsp_rdata, dq_out, dq_oe_n, dev_dq;
  wire [ADDR_W-1:0] addr;
  // resolved data pins: host where it drives, else the device or its float pattern
  wire [DATA_W-1:0] dq_in = (dq_out & ~dq_oe_n) | (dev_dq & dq_oe_n);
  int mismatches = 0;
  int tests_run = 0;
  int seed = 32'h6d6d;
  logic [7:0] shadow [256];
  logic sprot [256];
  logic [ADDR_W-1:0] a;
  logic [DATA_W-1:0] wd;
  flash_host DUT (.sys_clk(sys_clk), .nrst(nrst), .req_valid(req_valid), .req_ready(req_ready),
    .req_op(req_op), .req_addr(req_addr), .req_low_byte(req_low_byte), .req_wdata(req_wdata),
    .byte_mode(byte_mode), .flash_reset_req(flash_reset_req), .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata), .addr(addr), .dq_in(dq_in), .dq_out(dq_out), .dq_oe_n(dq_oe_n),
    .chip_sel_n(chip_sel_n), .out_en_n(out_en_n), .wr_en_n(wr_en_n), .flash_rst_n(flash_rst_n),
    .high_voltage_level(high_voltage_level), .byte_word_sel(byte_word_sel));
  flash_dev_model u_dev (.addr(addr), .bus(dq_in), .host_oe_n(dq_oe_n), .chip_sel_n(chip_sel_n),
    .out_en_n(out_en_n), .wr_en_n(wr_en_n), .flash_rst_n(flash_rst_n), .bad(bad),
    .high_voltage_level(high_voltage_level), .byte_word_sel(byte_word_sel), .dev_dq(dev_dq));
  initial forever #2 sys_clk = ~sys_clk;
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic print_verdict;
    if (mismatches == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // request held from a falling edge until the rising edge that takes it
  task automatic do_op(input logic [1:0] op, input logic [ADDR_W-1:0] ad, input logic lb,
    input logic [DATA_W-1:0] d, input logic bm);
    int n;
    n = 0;
    @(negedge sys_clk);
    req_valid = 1'b1;
    req_op = op;
    req_addr = ad;
    req_low_byte = lb;
    req_wdata = d;
    byte_mode = bm;
    while (req_ready !== 1'b1 && n < 400)
    begin
      @(negedge sys_clk);
      n++;
    end
    @(posedge sys_clk);
    @(negedge sys_clk);
    req_valid = 1'b0;
  endtask
  task automatic wr(input logic [ADDR_W-1:0] ad, input logic lb, input logic [DATA_W-1:0] d,
    input logic bm);
    logic [7:0] i;
    i = {ad[6:0], bm & lb};
    do_op(OP_WRITE, ad, lb, d, bm);
    if (!sprot[ad[19:12]]) shadow[i] &= d[7:0];
    if (!sprot[ad[19:12]] && !bm) shadow[i | 8'h01] &= d[15:8];
  endtask
  task automatic rd(input logic [ADDR_W-1:0] ad, input logic lb, input logic bm);
    int lat;
    logic [7:0] i;
    lat = 0;
    i = {ad[6:0], bm & lb};
    do_op(OP_READ, ad, lb, 16'h0000, bm);
    while (rsp_valid !== 1'b1 && lat < 400)
    begin
      @(negedge sys_clk);
      lat++;
    end
    check("read latency", lat, ACC_CYC + 3);
    check("word select", byte_word_sel, !bm);
    check("read data", rsp_rdata, bm ? {8'h00, shadow[i]} : {shadow[i | 8'h01], shadow[i]});
  endtask
  initial
  begin
    #80000;
    mismatches++;
    print_verdict;
  end
  initial
  begin
    foreach (shadow[i]) shadow[i] = 8'hFF;
    foreach (sprot[i]) sprot[i] = 1'b0;
    repeat (2) @(negedge sys_clk);
    nrst = 1'b1;
    rd(20'hABC12, 1'b0, 1'b0);
    // random writes read back in a random width, back to back
    repeat (16)
    begin
      a = ADDR_W'($random(seed));
      wd = DATA_W'($random(seed));
      wr(a, a[7], wd, a[8]);
      rd(a, a[7] ^ wd[0], wd[1]);
    end
    do_op(OP_PROTECT, 20'h35002, 1'b0, 16'h0000, 1'b0);
    sprot[8'h35] = 1'b1;
    wr(20'h35010, 1'b0, 16'h0000, 1'b0);
    rd(20'h35010, 1'b0, 1'b0);
    do_op(OP_UNPROTECT, 20'h35042, 1'b0, 16'h0000, 1'b0);
    sprot[8'h35] = 1'b0;
    wr(20'h35010, 1'b0, 16'h1234, 1'b0);
    rd(20'h35010, 1'b0, 1'b0);
    @(negedge sys_clk);
    flash_reset_req = 1'b1;
    repeat (20) @(negedge sys_clk);
    check("ready in reset", req_ready, 1'b0);
    check("reset pin", flash_rst_n, 1'b0);
    flash_reset_req = 1'b0;
    rd(20'h35010, 1'b0, 1'b1);
    check("strobe conflict", bad, 1'b0);
    print_verdict;
  end
endmodule // testbench
